// ==== verilog/bsim_cfg.svh ====
// register offsets, field positions and reset values of the status and mask block
// assumes inclusion by bare name from package and modules
`ifndef BSIM_CFG_SVH
`define BSIM_CFG_SVH

// register offsets
`define BSIM_ADDR_GLOBAL_EVENT 8'h18
`define BSIM_ADDR_CORE01_EVENT 8'h19
`define BSIM_ADDR_CORE01_LIVE 8'h1C
`define BSIM_ADDR_CORE23_LIVE 8'h1D
`define BSIM_ADDR_GLOBAL_MASK 8'h1E
`define BSIM_ADDR_CORE01_MASK 8'h1F

// live status field positions
`define BSIM_LIVE_CORE0_LIMIT 0
`define BSIM_LIVE_CORE0_VOUT_LOW 2
`define BSIM_LIVE_CORE0_ENABLED 3
`define BSIM_LIVE_CORE1_LIMIT 4
`define BSIM_LIVE_CORE2_LIMIT 0
`define BSIM_LIVE_CORE3_LIMIT 4

// global event and mask field positions
`define BSIM_GLB_LOAD_READY 0
`define BSIM_GLB_RESET_REG 1
`define BSIM_GLB_THERMAL_WARN 2

// core01 event and mask field positions
`define BSIM_C01_CORE0_LIMIT 0
`define BSIM_C01_RO_BIT 1
`define BSIM_C01_CORE0_GOOD 2
`define BSIM_C01_CORE1_LIMIT 4

// mask reset values
`define BSIM_GLOBAL_MASK_RST 8'h02
`define BSIM_CORE01_MASK_RST 8'h10

// internal event vector indices
`define BSIM_EV_LOAD_READY 0
`define BSIM_EV_RESET_REG 1
`define BSIM_EV_THERMAL_WARN 2
`define BSIM_EV_CORE0_LIMIT 3
`define BSIM_EV_CORE0_GOOD 4
`define BSIM_EV_CORE1_LIMIT 5
`define BSIM_EV_COUNT 6

`endif

// ==== verilog/bsim_pkg.sv ====
// types shared by the status and mask block
// assumes the cfg header is on the include path
`include "bsim_cfg.svh"
package bsim_pkg;
   // one bit per latched event
   typedef logic [`BSIM_EV_COUNT-1:0] bsim_ev_vec_t;
   // register byte
   typedef logic [7:0] bsim_byte_t;
endpackage

// ==== verilog/bsim_evt_if.sv ====
// carrier between top and event latch module
// assumes both ends share core_clk_in
`timescale 1ns/10ps
`default_nettype none
interface bsim_evt_if;
   import bsim_pkg::*;
   bsim_ev_vec_t src; // event source levels, rise sets the event
   bsim_ev_vec_t clr; // write-one-clear pulses
   bsim_ev_vec_t ev; // latched events
   modport ctrl (output src, output clr, input ev);
   modport latch (input src, input clr, output ev);
endinterface
`default_nettype wire

// ==== verilog/bsim_event_latch.sv ====
// sticky event latches with rising-edge set and write-one clear
// assumes source levels synchronous to core_clk_in
`timescale 1ns/10ps
`default_nettype none
`include "bsim_cfg.svh"
module bsim_event_latch
   import bsim_pkg::*;
(
   // clock and reset
   input wire logic core_clk_in,
   input wire logic reset_in,
   // event carrier
   bsim_evt_if.latch evt
);
   bsim_ev_vec_t prev_q; // previous source levels
   bsim_ev_vec_t ev_q; // latched event bits

   // source history for edge detection
   always_ff @(posedge core_clk_in or posedge reset_in)
   begin
      if (reset_in)
      begin
         prev_q <= '0;
      end
      else
      begin
         prev_q <= evt.src;
      end
   end

   // per-bit latch, a fresh rise beats a clear in the same cycle
   genvar k;
   generate
      for (k = 0; k < `BSIM_EV_COUNT; k = k + 1)
      begin : g_ev
         always_ff @(posedge core_clk_in or posedge reset_in)
         begin
            if (reset_in)
            begin
               ev_q[k] <= 1'b0;
            end
            else if (evt.src[k] && !prev_q[k])
            begin
               ev_q[k] <= 1'b1; // [R12] [R13] [R14]
            end
            else if (evt.clr[k])
            begin
               ev_q[k] <= 1'b0; // [R12]
            end
         end
      end
   endgenerate

   assign evt.ev = ev_q;
endmodule // bsim_event_latch
`default_nettype wire

// ==== verilog/bsim_top.sv ====
// live status, event and mask registers of a four-core step-down regulator
// assumes a register port driven by the serial interface, synchronous to core_clk_in
// What this block does
// [R1] core0 live current limit at 0x1C bit0
// [R2] core1 live current limit at 0x1C bit4
// [R3] 0x1D: core3 bit4, core2 bit0, rest zero
// [R4] 0x1C bit3 shows core0 enabled
// [R5] 0x1C bit2 high when core0 output low
// [R6] 0x1E bit2 blocks thermal warning interrupt
// [R7] 0x1E bit1 blocks reset interrupt, resets one
// [R8] 0x1E bit0 blocks load ready interrupt
// [R9] 0x1F bit4 blocks core1 limit, resets one
// [R10] 0x1F bit2 blocks core0 good interrupt
// [R11] 0x1F bit0 blocks core0 limit interrupt
// [R12] limit events latch, write one clears
// [R13] core0 good event latches, write one clears
// [R14] thermal warning event latches, write one clears
// [R15] interrupt while any unmasked event set
`timescale 1ns/10ps
`default_nettype none
`include "bsim_cfg.svh"
module bsim_top
   import bsim_pkg::*;
(
   // clock and reset
   input wire logic core_clk_in,
   input wire logic reset_in,
   // register port
   input wire logic [7:0] reg_addr_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   input wire logic [7:0] reg_wdata_in,
   output logic [7:0] reg_rdata_out,
   output logic reg_rvalid_out,
   // live converter state
   input wire logic core0_limit_live_in,
   input wire logic core1_limit_live_in,
   input wire logic core2_limit_live_in,
   input wire logic core3_limit_live_in,
   input wire logic core0_enabled_live_in,
   input wire logic core0_vout_low_live_in,
   input wire logic thermal_warn_live_in,
   input wire logic load_ready_in,
   // interrupt
   output logic irq_out
);
   bsim_evt_if evt (); // carrier to the latch module

   bsim_byte_t global_event_mask_q; // mask at 0x1E
   bsim_byte_t core01_event_mask_q; // mask at 0x1F
   logic started_q; // low only until the first edge after reset
   bsim_byte_t rdata_q; // read data register
   logic rvalid_q; // read answer strobe
   logic irq_q; // interrupt register
   bsim_byte_t core01_live; // live view of 0x1C
   bsim_byte_t core23_live; // live view of 0x1D
   bsim_byte_t global_event_rd; // event view of 0x18
   bsim_byte_t core01_event_rd; // event view of 0x19
   bsim_ev_vec_t mask_vec; // masks lined up with events
   bsim_ev_vec_t clr_vec; // write-one-clear pulses
   bsim_byte_t rd_mux; // selected read value

   // event latches
   bsim_event_latch u_latch (
      .core_clk_in(core_clk_in),
      .reset_in(reset_in),
      .evt(evt.latch)
   );

   // startup marker, source of the register-reset event
   always_ff @(posedge core_clk_in or posedge reset_in)
   begin
      if (reset_in)
      begin
         started_q <= 1'b0;
      end
      else
      begin
         started_q <= 1'b1;
      end
   end

   // live status assembly, never touched by the masks
   always_comb
   begin
      core01_live = 8'h00;
      core01_live[`BSIM_LIVE_CORE0_LIMIT] = core0_limit_live_in; // [R1]
      core01_live[`BSIM_LIVE_CORE1_LIMIT] = core1_limit_live_in; // [R2]
      core01_live[`BSIM_LIVE_CORE0_ENABLED] = core0_enabled_live_in; // [R4]
      core01_live[`BSIM_LIVE_CORE0_VOUT_LOW] = core0_vout_low_live_in; // [R5]
      core23_live = 8'h00; // [R3]
      core23_live[`BSIM_LIVE_CORE2_LIMIT] = core2_limit_live_in; // [R3]
      core23_live[`BSIM_LIVE_CORE3_LIMIT] = core3_limit_live_in; // [R3]
   end

   // event sources, latched on their rising edge
   always_comb
   begin
      evt.src = '0;
      evt.src[`BSIM_EV_LOAD_READY] = load_ready_in;
      evt.src[`BSIM_EV_RESET_REG] = ~started_q;
      evt.src[`BSIM_EV_THERMAL_WARN] = thermal_warn_live_in; // [R14]
      evt.src[`BSIM_EV_CORE0_LIMIT] = core0_limit_live_in; // [R12]
      evt.src[`BSIM_EV_CORE0_GOOD] = ~core0_vout_low_live_in; // [R13]
      evt.src[`BSIM_EV_CORE1_LIMIT] = core1_limit_live_in; // [R12]
   end

   // write-one-clear decode, writing zero leaves events alone
   always_comb
   begin
      clr_vec = '0;
      if (reg_wr_in && reg_addr_in == `BSIM_ADDR_GLOBAL_EVENT)
      begin
         clr_vec[`BSIM_EV_LOAD_READY] = reg_wdata_in[`BSIM_GLB_LOAD_READY];
         clr_vec[`BSIM_EV_RESET_REG] = reg_wdata_in[`BSIM_GLB_RESET_REG];
         clr_vec[`BSIM_EV_THERMAL_WARN] = reg_wdata_in[`BSIM_GLB_THERMAL_WARN]; // [R14]
      end
      else if (reg_wr_in && reg_addr_in == `BSIM_ADDR_CORE01_EVENT)
      begin
         clr_vec[`BSIM_EV_CORE0_LIMIT] = reg_wdata_in[`BSIM_C01_CORE0_LIMIT]; // [R12]
         clr_vec[`BSIM_EV_CORE0_GOOD] = reg_wdata_in[`BSIM_C01_CORE0_GOOD]; // [R13]
         clr_vec[`BSIM_EV_CORE1_LIMIT] = reg_wdata_in[`BSIM_C01_CORE1_LIMIT]; // [R12]
      end
      evt.clr = clr_vec;
   end

   // global mask register, bit1 comes up set
   always_ff @(posedge core_clk_in or posedge reset_in)
   begin
      if (reset_in)
      begin
         global_event_mask_q <= `BSIM_GLOBAL_MASK_RST; // [R6] [R7] [R8]
      end
      else if (reg_wr_in && reg_addr_in == `BSIM_ADDR_GLOBAL_MASK)
      begin
         global_event_mask_q <= reg_wdata_in;
      end
   end

   // core01 mask register, bit1 is read-only zero
   always_ff @(posedge core_clk_in or posedge reset_in)
   begin
      if (reset_in)
      begin
         core01_event_mask_q <= `BSIM_CORE01_MASK_RST; // [R9] [R10] [R11]
      end
      else if (reg_wr_in && reg_addr_in == `BSIM_ADDR_CORE01_MASK)
      begin
         core01_event_mask_q <= reg_wdata_in;
         core01_event_mask_q[`BSIM_C01_RO_BIT] <= 1'b0;
      end
   end

   // masks lined up with the event vector
   always_comb
   begin
      mask_vec = '0;
      mask_vec[`BSIM_EV_LOAD_READY] = global_event_mask_q[`BSIM_GLB_LOAD_READY]; // [R8]
      mask_vec[`BSIM_EV_RESET_REG] = global_event_mask_q[`BSIM_GLB_RESET_REG]; // [R7]
      mask_vec[`BSIM_EV_THERMAL_WARN] = global_event_mask_q[`BSIM_GLB_THERMAL_WARN]; // [R6]
      mask_vec[`BSIM_EV_CORE0_LIMIT] = core01_event_mask_q[`BSIM_C01_CORE0_LIMIT]; // [R11]
      mask_vec[`BSIM_EV_CORE0_GOOD] = core01_event_mask_q[`BSIM_C01_CORE0_GOOD]; // [R10]
      mask_vec[`BSIM_EV_CORE1_LIMIT] = core01_event_mask_q[`BSIM_C01_CORE1_LIMIT]; // [R9]
   end

   // interrupt, registered from latched and unmasked events
   always_ff @(posedge core_clk_in or posedge reset_in)
   begin
      if (reset_in)
      begin
         irq_q <= 1'b0;
      end
      else
      begin
         irq_q <= |(evt.ev & ~mask_vec); // [R15]
      end
   end

   // event register views
   always_comb
   begin
      global_event_rd = 8'h00;
      global_event_rd[`BSIM_GLB_LOAD_READY] = evt.ev[`BSIM_EV_LOAD_READY];
      global_event_rd[`BSIM_GLB_RESET_REG] = evt.ev[`BSIM_EV_RESET_REG];
      global_event_rd[`BSIM_GLB_THERMAL_WARN] = evt.ev[`BSIM_EV_THERMAL_WARN];
      core01_event_rd = 8'h00;
      core01_event_rd[`BSIM_C01_CORE0_LIMIT] = evt.ev[`BSIM_EV_CORE0_LIMIT];
      core01_event_rd[`BSIM_C01_CORE0_GOOD] = evt.ev[`BSIM_EV_CORE0_GOOD];
      core01_event_rd[`BSIM_C01_CORE1_LIMIT] = evt.ev[`BSIM_EV_CORE1_LIMIT];
   end

   // read address decode, unmapped reads zero
   always_comb
   begin
      if (reg_addr_in == `BSIM_ADDR_CORE01_LIVE)
      begin
         rd_mux = core01_live;
      end
      else if (reg_addr_in == `BSIM_ADDR_CORE23_LIVE)
      begin
         rd_mux = core23_live;
      end
      else if (reg_addr_in == `BSIM_ADDR_GLOBAL_MASK)
      begin
         rd_mux = global_event_mask_q;
      end
      else if (reg_addr_in == `BSIM_ADDR_CORE01_MASK)
      begin
         rd_mux = core01_event_mask_q;
      end
      else if (reg_addr_in == `BSIM_ADDR_GLOBAL_EVENT)
      begin
         rd_mux = global_event_rd;
      end
      else if (reg_addr_in == `BSIM_ADDR_CORE01_EVENT)
      begin
         rd_mux = core01_event_rd;
      end
      else
      begin
         rd_mux = 8'h00;
      end
   end

   // read data register, holds until the next read
   always_ff @(posedge core_clk_in or posedge reset_in)
   begin
      if (reset_in)
      begin
         rdata_q <= 8'h00;
         rvalid_q <= 1'b0;
      end
      else
      begin
         rvalid_q <= reg_rd_in;
         if (reg_rd_in)
         begin
            rdata_q <= rd_mux;
         end
      end
   end

   assign reg_rdata_out = rdata_q;
   assign reg_rvalid_out = rvalid_q;
   assign irq_out = irq_q;
endmodule // bsim_top
`default_nettype wire

// ==== sim/bsim_assertions.sv ====
// port checker for the status and mask block
// assumes bind onto bsim_top, one clock domain
`timescale 1ns/10ps
`default_nettype none
`include "bsim_cfg.svh"
module bsim_assertions
   import bsim_pkg::*;
(
   // clock and reset
   input wire logic core_clk_in,
   input wire logic reset_in,
   // register port
   input wire logic [7:0] reg_addr_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   input wire logic [7:0] reg_wdata_in,
   input wire logic [7:0] reg_rdata_out,
   input wire logic reg_rvalid_out,
   // live converter state
   input wire logic core0_limit_live_in,
   input wire logic core1_limit_live_in,
   input wire logic core2_limit_live_in,
   input wire logic core3_limit_live_in,
   input wire logic core0_enabled_live_in,
   input wire logic core0_vout_low_live_in,
   input wire logic thermal_warn_live_in,
   input wire logic load_ready_in,
   // interrupt
   input wire logic irq_out
);
   logic [7:0] gm_q; // shadow of global mask
   logic [7:0] cm_q; // shadow of core01 mask
   wire logic all_blk = (&gm_q[2:0]) && cm_q[4] && cm_q[2] && cm_q[0]; // every event blocked
   wire logic rd1c = reg_rd_in && reg_addr_in == `BSIM_ADDR_CORE01_LIVE;
   wire logic rd1d = reg_rd_in && reg_addr_in == `BSIM_ADDR_CORE23_LIVE;
   wire logic rd1e = reg_rd_in && reg_addr_in == `BSIM_ADDR_GLOBAL_MASK;
   wire logic rd1f = reg_rd_in && reg_addr_in == `BSIM_ADDR_CORE01_MASK;
   wire logic wr1e = reg_wr_in && reg_addr_in == `BSIM_ADDR_GLOBAL_MASK;
   wire logic wr1f = reg_wr_in && reg_addr_in == `BSIM_ADDR_CORE01_MASK;
   // mask shadows follow host writes
   always_ff @(posedge core_clk_in or posedge reset_in)
      if (reset_in)
      begin
         gm_q <= `BSIM_GLOBAL_MASK_RST;
         cm_q <= `BSIM_CORE01_MASK_RST;
      end
      else
      begin
         if (wr1e) gm_q <= reg_wdata_in;
         if (wr1f) cm_q <= reg_wdata_in;
      end
   default clocking @(posedge core_clk_in); endclocking
   default disable iff (reset_in);
   a_read_answer: assert property (reg_rd_in |=> reg_rvalid_out)
      else $error("read without answer");
   a_core0_limit: assert property (rd1c |=> reg_rdata_out[0] == $past(core0_limit_live_in))
      else $error("core0 limit bit wrong");
   a_core1_limit: assert property (rd1c |=> reg_rdata_out[4] == $past(core1_limit_live_in))
      else $error("core1 limit bit wrong");
   a_core0_enabled: assert property (rd1c |=> reg_rdata_out[3] == $past(core0_enabled_live_in))
      else $error("core0 enable bit wrong");
   a_core0_vout: assert property (rd1c |=> reg_rdata_out[2] == $past(core0_vout_low_live_in))
      else $error("core0 vout bit wrong");
   a_core23_live: assert property (rd1d |=> reg_rdata_out ==
      {3'h0, $past(core3_limit_live_in), 3'h0, $past(core2_limit_live_in)})
      else $error("core23 status wrong");
   // readback against the shadow, any spacing between write and read
   a_gmask_back: assert property (rd1e |=> reg_rdata_out == $past(gm_q))
      else $error("global mask readback wrong");
   a_cmask_back: assert property (rd1f |=> reg_rdata_out == ($past(cm_q) & 8'hFD))
      else $error("core01 mask readback wrong");
   a_irq_blocked: assert property (all_blk ##1 all_blk |-> !irq_out)
      else $error("irq while all masked");
   a_irq_raise: assert property ($rose(core0_limit_live_in) && !cm_q[0] && !reg_wr_in
      ##1 !reg_wr_in |=> irq_out)
      else $error("limit event gave no irq");
   c_read_core23: cover property (rd1d);
   c_irq_rise: cover property ($rose(irq_out));
   c_mask_write: cover property (wr1f);
endmodule // bsim_assertions
bind bsim_top bsim_assertions chk (.*);
`default_nettype wire

// ==== sim/bsim_host.sv ====
// host model driving the register port
// assumes requests start one ns after a rising edge
`timescale 1ns/10ps
`default_nettype none
module bsim_host (
   // clock
   input wire logic core_clk_in,
   // register port
   output logic [7:0] reg_addr_out,
   output logic reg_wr_out,
   output logic reg_rd_out,
   output logic [7:0] reg_wdata_out,
   input wire logic [7:0] reg_rdata_in,
   input wire logic reg_rvalid_in
);
   // idle bus at time zero
   initial
   begin
      reg_addr_out = 8'h00;
      reg_wr_out = 1'h0;
      reg_rd_out = 1'h0;
      reg_wdata_out = 8'h00;
   end
   // one write strobe, then scramble released lines
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk_in);
      #1;
      reg_addr_out = a;
      reg_wdata_out = d;
      reg_wr_out = 1'h1;
      @(posedge core_clk_in);
      #1;
      reg_wr_out = 1'h0;
      reg_addr_out = ~a;
      reg_wdata_out = ~d;
   endtask
   // one read strobe, answer taken the next cycle
   task automatic rd_reg(input logic [7:0] a, output logic [7:0] d, output logic v);
      @(posedge core_clk_in);
      #1;
      reg_addr_out = a;
      reg_rd_out = 1'h1;
      @(posedge core_clk_in);
      #1;
      reg_rd_out = 1'h0;
      reg_addr_out = ~a;
      d = reg_rdata_in;
      v = reg_rvalid_in;
   endtask
endmodule // bsim_host
`default_nettype wire

// ==== sim/bsim_top_tb.sv ====
// self-checking bench for the status and mask block
// assumes the host model and checker are compiled alongside
`timescale 1ns/10ps
`default_nettype none
module bsim_top_tb;
   logic clk = 1'h0;
   logic rst = 1'h1;
   logic [7:0] lv; // live sources, bit2 is output good
   logic [7:0] addr, wdata, rdata, d, b, rd_d;
   logic wr, rd, rvalid, irq, rd_v;
   int i, error_cnt, checks_done, cyc_cnt;
   logic [7:0] ma[5] = '{8'h1F, 8'h1F, 8'h1F, 8'h1E, 8'h1E}; // mask register
   logic [7:0] ea[5] = '{8'h19, 8'h19, 8'h19, 8'h18, 8'h18}; // event register
   logic [7:0] mall[5] = '{8'h15, 8'h15, 8'h15, 8'h07, 8'h07}; // all blocked
   int bp[5] = '{0, 4, 2, 2, 0}; // event bit
   always #2 clk = ~clk;
   bsim_host host (.core_clk_in(clk), .reg_addr_out(addr), .reg_wr_out(wr), .reg_rd_out(rd),
      .reg_wdata_out(wdata), .reg_rdata_in(rdata), .reg_rvalid_in(rvalid));
   bsim_top uut (.core_clk_in(clk), .reset_in(rst), .reg_addr_in(addr), .reg_wr_in(wr),
      .reg_rd_in(rd), .reg_wdata_in(wdata), .reg_rdata_out(rdata), .reg_rvalid_out(rvalid),
      .core0_limit_live_in(lv[0]), .core1_limit_live_in(lv[1]), .core2_limit_live_in(lv[5]),
      .core3_limit_live_in(lv[6]), .core0_enabled_live_in(lv[7]),
      .core0_vout_low_live_in(~lv[2]), .thermal_warn_live_in(lv[3]),
      .load_ready_in(lv[4]), .irq_out(irq));
   // expected live status bytes
   function automatic logic [7:0] exp_1c(input logic [7:0] v);
      return {3'h0, v[1], v[7], ~v[2], 1'h0, v[0]};
   endfunction
   function automatic logic [7:0] exp_1d(input logic [7:0] v);
      return {3'h0, v[6], 3'h0, v[5]};
   endfunction
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
      host.rd_reg(a, rd_d, rd_v);
      chk(rd_d, exp);
      chk({7'h0, rd_v}, 8'h01);
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic give_verdict;
      $display("checks %0d errors %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // hang guard
   always @(posedge clk)
   begin
      cyc_cnt++;
      if (cyc_cnt == 5000)
      begin
         error_cnt++;
         give_verdict;
      end
   end
   initial
   begin
      lv = 8'h00;
      void'($urandom(66));
      repeat (2) @(posedge clk);
      #1;
      rst = 1'h0;
      rchk(8'h1E, 8'h02);
      rchk(8'h1F, 8'h10);
      rchk(8'h55, 8'h00);
      rchk(8'h18, 8'h02);
      rchk(8'h19, 8'h00);
      host.wr_reg(8'h1E, 8'h00);
      cyc(1);
      chk({7'h0, irq}, 8'h01);
      $display("test defaults done");
      for (i = 0; i < 8; i++)
      begin
         lv = 8'($urandom);
         d = 8'($urandom);
         host.wr_reg(8'h1C, ~d);
         rchk(8'h1C, exp_1c(lv));
         rchk(8'h1D, exp_1d(lv));
         host.wr_reg(8'h1E, d);
         rchk(8'h1E, d);
         host.wr_reg(8'h1F, d);
         rchk(8'h1F, d & 8'hFD);
      end
      $display("test live and masks done");
      lv = 8'h00;
      host.wr_reg(8'h1E, 8'h07);
      host.wr_reg(8'h1F, 8'h15);
      host.wr_reg(8'h18, 8'hFF);
      host.wr_reg(8'h19, 8'hFF);
      for (i = 0; i < 5; i++)
      begin
         b = 8'h01 << bp[i];
         lv[i] = 1'h1;
         cyc(3);
         chk({7'h0, irq}, 8'h00);
         host.wr_reg(ea[i], ~b);
         rchk(ea[i], b);
         host.wr_reg(ma[i], mall[i] & ~b);
         cyc(1);
         chk({7'h0, irq}, 8'h01);
         rchk(8'h1C, exp_1c(lv));
         host.wr_reg(ea[i], b);
         cyc(1);
         chk({7'h0, irq}, 8'h00);
         rchk(ea[i], 8'h00);
         host.wr_reg(ma[i], mall[i]);
         lv[i] = 1'h0;
      end
      $display("test events done");
      give_verdict;
   end
endmodule // bsim_top_tb
`default_nettype wire
